// file: logic/rbel_loader.sv
// Reset release boot sequencer with endian straps and ROM packing
// Operation
// - Little-endian order unless endian-select strap asks otherwise.
// - Endian-select strap at 0 selects big-endian order.
// - With correction, 16-bit data on both lanes, 8-bit on low lane.
// - Little-endian behaviour unchanged whatever level the correction strap has.
// - External reset low forces internal reset and reset state.
// - Leaving internal reset starts the core per strapped boot mode.
// - Emulation boot stalls core until release, then start at 0.
// - Memory boot copies first 1K bytes of ROM space to 0.
// - Narrow ROM reads are packed into 32-bit words.
// - Copy runs as one single-frame block transfer.
// - After the block completes, core leaves stall and runs from 0.
//
// The strobed register port and the register offsets are this design's own decisions.
`include "rbel_params.svh"
`timescale 1ns/1ps
`default_nettype none

module rbel_loader #(
  parameter int BOOT_BYTES = `RBEL_BOOT_BYTES,
  parameter int RADDR_W    = 8
) (
  // Clock and resets
  input  wire logic                          clk,
  input  wire logic                          rst,
  input  wire logic                          ext_reset_n,
  // Straps
  input  wire logic                          endian_select_strap,
  input  wire logic                          endian_correction_strap,
  input  wire logic                          boot_mode_strap,
  input  wire logic                          rom_width_strap,
  // Emulator
  input  wire logic                          emu_release,
  // Register port
  input  wire logic [RADDR_W-1:0]            reg_addr,
  input  wire logic [31:0]                   reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  output logic      [31:0]                   reg_rdata,
  // Boot ROM on the external memory port
  output logic                               rom_cs,
  output logic                               rom_oe,
  output logic      [$clog2(BOOT_BYTES)-1:0] rom_addr,
  output logic                               upper_byte_lane,
  output logic                               lower_byte_lane,
  input  wire logic [15:0]                   external_data_lines,
  // Copy destination write port
  output logic                               mem_wr_valid,
  output logic      [31:0]                   mem_wr_addr,
  output logic      [31:0]                   mem_wr_data,
  input  wire logic                          mem_wr_ready,
  // Core control
  output logic                               core_reset,
  output logic                               core_stall,
  output logic                               core_start,
  output logic      [31:0]                   core_start_addr,
  output logic                               big_endian
);

  // ----------------------------------------------------------------
  // Derived sizes
  // ----------------------------------------------------------------
  localparam int WORDS  = BOOT_BYTES / `RBEL_WORD_BYTES;
  localparam int WW     = $clog2(WORDS);
  localparam int RA     = $clog2(BOOT_BYTES);
  localparam logic [7:0] STROBE_LAST = 8'(`RBEL_ROM_STROBE_CYC - 1);
  localparam logic [WW-1:0] WORD_LAST = WW'(WORDS - 1);

  // Refuse sizes the counters cannot serve
  initial begin
    if (BOOT_BYTES < 8 || (BOOT_BYTES & (BOOT_BYTES - 1)) != 0) begin
      $error("BOOT_BYTES must be a power of two of at least 8");
    end
    if (RADDR_W < 8) begin
      $error("RADDR_W must be at least 8");
    end
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  rbel_pkg::rbel_state_type state_q;
  rbel_pkg::rbel_state_type state_d;
  logic          int_reset;
  logic          big_q;
  logic          corr_on_q;
  logic          emu_q;
  logic          wide_q;
  logic          done_q;
  logic [7:0]    timer_q;
  logic          gap_q;
  logic [1:0]    part_q;
  logic [RA-1:0] rom_addr_q;
  logic [WW-1:0] word_q;
  logic [31:0]   acc_q;
  logic [31:0]   acc_d;
  logic          lane_hi;
  logic          lane_lo;
  logic          sw_emu_go;
  logic          emu_go;
  logic          unit_done;
  logic          word_full;
  logic          wr_fire;
  logic          wr_last;
  logic [31:0]   rdata_d;

  // Internal reset follows the pin and the system reset
  assign int_reset = rst | ~ext_reset_n;

  assign sw_emu_go = reg_wr & (reg_addr == RADDR_W'(`RBEL_REG_CTRL))
                   & reg_wdata[`RBEL_CTRL_EMU_GO];
  assign emu_go    = emu_release | sw_emu_go;
  assign unit_done = (state_q == rbel_pkg::ST_COPY_RD) & ~gap_q
                   & (timer_q == STROBE_LAST);
  assign word_full = part_q == (wide_q ? 2'h1 : 2'h3);
  assign wr_fire   = (state_q == rbel_pkg::ST_COPY_WR) & mem_wr_ready;
  assign wr_last   = wr_fire & (word_q == WORD_LAST);

  // ----------------------------------------------------------------
  // Strap capture
  // ----------------------------------------------------------------
  // Straps sampled on the first cycle out of reset, then frozen
  always_ff @(posedge clk) begin
    if (int_reset) begin
      big_q     <= 1'b0;
      corr_on_q <= 1'b0;
      emu_q     <= 1'b0;
      wide_q    <= 1'b0;
    end else if (state_q == rbel_pkg::ST_HOLD) begin
      big_q     <= endian_select_strap == `RBEL_BIG_LEVEL;
      corr_on_q <= endian_correction_strap == `RBEL_CORR_ON_LEVEL;
      emu_q     <= boot_mode_strap == `RBEL_EMU_BOOT_LEVEL;
      wide_q    <= rom_width_strap == `RBEL_ROM16_LEVEL;
    end
  end

  // ----------------------------------------------------------------
  // Boot sequencer
  // ----------------------------------------------------------------
  // Next state of the sequencer
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      rbel_pkg::ST_HOLD: begin
        state_d = (boot_mode_strap == `RBEL_EMU_BOOT_LEVEL)
                ? rbel_pkg::ST_EMU_WAIT : rbel_pkg::ST_COPY_RD;
      end
      rbel_pkg::ST_EMU_WAIT: begin
        if (emu_go) begin
          state_d = rbel_pkg::ST_RUN;
        end
      end
      rbel_pkg::ST_COPY_RD: begin
        if (unit_done && word_full) begin
          state_d = rbel_pkg::ST_COPY_WR;
        end
      end
      rbel_pkg::ST_COPY_WR: begin
        if (wr_last) begin
          state_d = rbel_pkg::ST_RUN;
        end else if (wr_fire) begin
          state_d = rbel_pkg::ST_COPY_RD;
        end
      end
      rbel_pkg::ST_RUN: begin
        state_d = rbel_pkg::ST_RUN;
      end
      default: begin
        state_d = rbel_pkg::ST_HOLD;
      end
    endcase
  end

  // State register, held in reset by the pin
  always_ff @(posedge clk) begin
    if (int_reset) begin
      state_q <= rbel_pkg::ST_HOLD;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------
  // ROM access timing
  // ----------------------------------------------------------------
  // Strobe counter with one idle cycle between ROM reads
  always_ff @(posedge clk) begin
    if (int_reset) begin
      timer_q <= 8'h00;
      gap_q   <= 1'b0;
    end else if (state_q == rbel_pkg::ST_COPY_RD) begin
      if (gap_q) begin
        gap_q <= 1'b0;
      end else if (unit_done) begin
        timer_q <= 8'h00;
        gap_q   <= 1'b1;
      end else begin
        timer_q <= timer_q + 8'h01;
      end
    end else begin
      timer_q <= 8'h00;
      gap_q   <= 1'b0;
    end
  end

  // ROM byte address and packing position
  always_ff @(posedge clk) begin
    if (int_reset) begin
      rom_addr_q <= '0;
      part_q     <= 2'h0;
    end else if (unit_done) begin
      rom_addr_q <= rom_addr_q + (wide_q ? RA'(2) : RA'(1));
      part_q     <= word_full ? 2'h0 : part_q + 2'h1;
    end
  end

  // ----------------------------------------------------------------
  // Lane mapping and packing
  // ----------------------------------------------------------------
  rbel_lane_pack u_pack (
    .ext_data (external_data_lines),
    .wide     (wide_q),
    .big      (big_q),
    .corr_on  (corr_on_q),
    .part     (part_q),
    .word_in  (acc_q),
    .word_out (acc_d),
    .lane_hi  (lane_hi),
    .lane_lo  (lane_lo)
  );

  // Accumulator takes each unit at the end of its strobe
  always_ff @(posedge clk) begin
    if (int_reset) begin
      acc_q <= 32'h0000_0000;
    end else if (unit_done) begin
      acc_q <= acc_d;
    end
  end

  // ----------------------------------------------------------------
  // Block transfer to the destination
  // ----------------------------------------------------------------
  // Word counter of the single block
  always_ff @(posedge clk) begin
    if (int_reset) begin
      word_q <= '0;
      done_q <= 1'b0;
    end else if (wr_fire) begin
      word_q <= word_q + WW'(1);
      done_q <= done_q | wr_last;
    end
  end

  assign mem_wr_valid = state_q == rbel_pkg::ST_COPY_WR;
  assign mem_wr_addr  = `RBEL_DEST_BASE + {{(30-WW){1'b0}}, word_q, 2'b00};
  assign mem_wr_data  = acc_q;

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // ROM pins and lane enables
  assign rom_cs          = state_q == rbel_pkg::ST_COPY_RD;
  assign rom_oe          = rom_cs & ~gap_q;
  assign rom_addr        = rom_addr_q;
  assign upper_byte_lane = rom_oe & lane_hi;
  assign lower_byte_lane = rom_oe & lane_lo;
  assign big_endian      = big_q;

  // Core reset, stall and start pulse
  always_ff @(posedge clk) begin
    if (int_reset) begin
      core_reset <= 1'b1;
      core_stall <= 1'b1;
      core_start <= 1'b0;
    end else begin
      core_reset <= 1'b0;
      core_stall <= state_d != rbel_pkg::ST_RUN;
      core_start <= (state_d == rbel_pkg::ST_RUN)
                  & (state_q != rbel_pkg::ST_RUN);
    end
  end

  assign core_start_addr = `RBEL_CORE_START_ADDR;

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  // Read mux, unmapped reads return zero
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (reg_addr == RADDR_W'(`RBEL_REG_STATUS)) begin
      rdata_d[`RBEL_ST_BIG]   = big_q;
      rdata_d[`RBEL_ST_CORR]  = corr_on_q;
      rdata_d[`RBEL_ST_EMU]   = emu_q;
      rdata_d[`RBEL_ST_WIDE]  = wide_q;
      rdata_d[`RBEL_ST_STALL] = core_stall;
      rdata_d[`RBEL_ST_DONE]  = done_q;
      rdata_d[`RBEL_ST_STATE_LO +: 3] = state_q;
    end else if (reg_addr == RADDR_W'(`RBEL_REG_COUNT)) begin
      rdata_d[WW:0] = {done_q, word_q}; // Reaches WORDS once done
    end
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      reg_rdata <= rdata_d;
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_last_write;
    (state_q == rbel_pkg::ST_COPY_WR) && mem_wr_ready
      && (word_q == WORD_LAST);
  endsequence

  sequence s_core_go;
    !core_stall && core_start && (core_start_addr == 32'h0000_0000);
  endsequence

  a_reset_holds_core: assert property (@(posedge clk)
    int_reset |=> core_reset && core_stall
      && (state_q == rbel_pkg::ST_HOLD))
    else $error("core not held during reset");

  a_little_default: assert property (@(posedge clk)
    disable iff (int_reset)
    !int_reset && (state_q == rbel_pkg::ST_HOLD)
      && endian_select_strap |=> !big_q)
    else $error("little endian not taken");

  a_big_select: assert property (@(posedge clk)
    disable iff (int_reset)
    !int_reset && (state_q == rbel_pkg::ST_HOLD)
      && !endian_select_strap |=> big_q)
    else $error("big endian not taken");

  a_straps_held: assert property (@(posedge clk)
    disable iff (int_reset)
    (state_q != rbel_pkg::ST_HOLD) |=> $stable(big_q) && $stable(wide_q)
      && $stable(emu_q) && $stable(corr_on_q))
    else $error("strap changed after release");

  a_lane_map: assert property (@(posedge clk)
    disable iff (int_reset)
    rom_oe && (corr_on_q || !big_q) |->
      lower_byte_lane && (upper_byte_lane == wide_q))
    else $error("wrong byte lanes");

  a_boot_start: assert property (@(posedge clk)
    disable iff (int_reset)
    !int_reset && (state_q == rbel_pkg::ST_HOLD) |=> !core_reset
      && (state_q == (emu_q ? rbel_pkg::ST_EMU_WAIT
                            : rbel_pkg::ST_COPY_RD)))
    else $error("wrong boot path");

  a_emu_stall: assert property (@(posedge clk)
    disable iff (int_reset)
    (state_q == rbel_pkg::ST_EMU_WAIT) && !emu_go |=> core_stall)
    else $error("core left stall without emulator");

  a_emu_release: assert property (@(posedge clk)
    disable iff (int_reset)
    (state_q == rbel_pkg::ST_EMU_WAIT) && emu_go |=> s_core_go)
    else $error("emulator release not honoured");

  a_strobe_len: assert property (@(posedge clk)
    disable iff (int_reset)
    $rose(rom_oe) |-> rom_oe[*4] ##1 !rom_oe)
    else $error("ROM strobe length wrong");

  a_copy_stalled: assert property (@(posedge clk)
    disable iff (int_reset)
    mem_wr_valid |-> core_stall
      && (mem_wr_addr[1:0] == 2'b00) && !done_q)
    else $error("copy outside stall");

  a_block_done: assert property (@(posedge clk)
    disable iff (int_reset)
    s_last_write |=> s_core_go ##1 !core_start && !core_stall)
    else $error("core not released after block");

endmodule

`default_nettype wire

// file: logic/rbel_params.svh
// Constants for the reset, boot and endian loader
`ifndef RBEL_PARAMS_SVH
`define RBEL_PARAMS_SVH

// ----------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------
`define RBEL_CLK_MHZ          40
`define RBEL_ROM_STROBE_NS    100
`define RBEL_ROM_STROBE_CYC   ((`RBEL_ROM_STROBE_NS * `RBEL_CLK_MHZ + 999) / 1000)

// ----------------------------------------------------------------
// Boot image
// ----------------------------------------------------------------
`define RBEL_BOOT_BYTES       1024
`define RBEL_WORD_BYTES       4
`define RBEL_DEST_BASE        32'h0000_0000
`define RBEL_CORE_START_ADDR  32'h0000_0000

// ----------------------------------------------------------------
// Strap levels
// ----------------------------------------------------------------
`define RBEL_BIG_LEVEL        1'b0
`define RBEL_CORR_ON_LEVEL    1'b0
`define RBEL_EMU_BOOT_LEVEL   1'b1
`define RBEL_ROM16_LEVEL      1'b1

// ----------------------------------------------------------------
// Register offsets and fields
// ----------------------------------------------------------------
`define RBEL_REG_CTRL         8'h00
`define RBEL_REG_STATUS       8'h04
`define RBEL_REG_COUNT        8'h08
`define RBEL_CTRL_EMU_GO      0
`define RBEL_ST_BIG           0
`define RBEL_ST_CORR          1
`define RBEL_ST_EMU           2
`define RBEL_ST_WIDE          3
`define RBEL_ST_STALL         4
`define RBEL_ST_DONE          5
`define RBEL_ST_STATE_LO      8

`endif

// file: logic/rbel_pkg.sv
// Types for the reset, boot and endian loader
package rbel_pkg;

  // ----------------------------------------------------------------
  // Boot sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_HOLD     = 3'h0,
    ST_EMU_WAIT = 3'h1,
    ST_COPY_RD  = 3'h2,
    ST_COPY_WR  = 3'h3,
    ST_RUN      = 3'h4
  } rbel_state_type;

endpackage

// file: logic/rbel_lane_pack.sv
// Byte-lane selection and word packing for narrow boot ROM reads
`timescale 1ns/1ps
`default_nettype none

module rbel_lane_pack (
  // Raw external data and strap state
  input  wire logic [15:0] ext_data,
  input  wire logic        wide,
  input  wire logic        big,
  input  wire logic        corr_on,
  // Packing position
  input  wire logic [1:0]  part,
  input  wire logic [31:0] word_in,
  // Results
  output logic      [31:0] word_out,
  output logic             lane_hi,
  output logic             lane_lo
);

  logic [7:0] byte_sel;

  // Narrow data lane; without correction big-endian bytes sit high
  always_comb begin
    lane_hi  = wide | (big & ~corr_on);
    lane_lo  = wide | ~big | corr_on;
    byte_sel = (big & ~corr_on) ? ext_data[15:8] : ext_data[7:0];
  end

  // Place the unit into the word in the strapped byte order
  always_comb begin
    word_out = word_in;
    if (wide) begin
      if (big ^ part[0]) begin
        word_out[31:16] = ext_data;
      end else begin
        word_out[15:0] = ext_data;
      end
    end else begin
      unique case (big ? ~part : part)
        2'h0: word_out[7:0]   = byte_sel;
        2'h1: word_out[15:8]  = byte_sel;
        2'h2: word_out[23:16] = byte_sel;
        2'h3: word_out[31:24] = byte_sel;
      endcase
    end
  end

endmodule

`default_nettype wire

// file: test/rbel_rom_model.sv
// Boot ROM and copy destination model for the loader bench
`timescale 1ns/1ps
`default_nettype none

module rbel_rom_model #(
  parameter int BOOT_BYTES = 32
) (
  // Clock
  input  wire logic                          clk,
  // ROM side
  input  wire logic                          rom_cs,
  input  wire logic                          rom_oe,
  input  wire logic [$clog2(BOOT_BYTES)-1:0] rom_addr,
  output logic      [15:0]                   external_data_lines,
  // Board wiring of the ROM
  input  wire logic                          wide,
  input  wire logic                          big,
  input  wire logic                          corr_on,
  // Destination side
  input  wire logic                          slow,
  output logic                               mem_wr_ready
);
  logic [15:0] idle_q = 16'hC3A5;
  logic [7:0]  lo_b;
  logic [7:0]  hi_b;

  // Image byte at an offset, laid down in the system byte order
  function automatic logic [7:0] rom_byte(input int a);
    return 8'(a * 29) ^ 8'h5A;
  endfunction

  // Released bus shows a moving pattern, never the last value
  always @(posedge clk) begin
    idle_q <= idle_q + 16'h9E37;
  end

  // Narrow device sits on one lane, wide device on both
  always_comb begin
    lo_b = rom_byte(int'(rom_addr));
    hi_b = rom_byte(int'(rom_addr) + 1);
    if (!(rom_cs && rom_oe))
      external_data_lines = idle_q;
    else if (wide)
      external_data_lines = {hi_b, lo_b};
    else if (big && !corr_on)
      external_data_lines = {lo_b, idle_q[7:0]};
    else
      external_data_lines = {idle_q[15:8], lo_b};
  end

  // Destination accepts at once or after random stalls
  initial mem_wr_ready = 1'b0;
  always @(posedge clk) begin
    mem_wr_ready <= slow ? ($urandom_range(2) == 0) : 1'b1;
  end
endmodule
`default_nettype wire

// file: test/rbel_loader_tb.sv
// Self-checking bench for the reset, boot and endian loader
`timescale 1ns/1ps
`default_nettype none

module rbel_loader_tb;
  localparam int BB = 32;
  localparam int NW = BB / 4;
  localparam int AW = $clog2(BB);

  logic          clk = 1'b0;
  logic          rst, ext_reset_n, emu_release, reg_wr, reg_rd, slow;
  logic          sel_strap, corr_strap, boot_strap, width_strap;
  logic [7:0]    reg_addr;
  logic [31:0]   reg_wdata, reg_rdata, mem_wr_addr, mem_wr_data, start_addr;
  logic [AW-1:0] rom_addr;
  logic [15:0]   ext_data;
  logic          rom_cs, rom_oe, up_lane, lo_lane, mem_wr_valid, mem_wr_ready;
  logic          core_reset, core_stall, core_start, big_endian;
  logic          cfg_big, cfg_corr, cfg_wide;
  logic [31:0]   d;
  int            errors, samples_checked, wcnt;

  rbel_loader #(.BOOT_BYTES(BB)) uut (
    .clk(clk), .rst(rst), .ext_reset_n(ext_reset_n),
    .endian_select_strap(sel_strap), .endian_correction_strap(corr_strap),
    .boot_mode_strap(boot_strap), .rom_width_strap(width_strap),
    .emu_release(emu_release), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .rom_cs(rom_cs), .rom_oe(rom_oe), .rom_addr(rom_addr),
    .upper_byte_lane(up_lane), .lower_byte_lane(lo_lane),
    .external_data_lines(ext_data), .mem_wr_valid(mem_wr_valid),
    .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data),
    .mem_wr_ready(mem_wr_ready), .core_reset(core_reset),
    .core_stall(core_stall), .core_start(core_start),
    .core_start_addr(start_addr), .big_endian(big_endian));

  rbel_rom_model #(.BOOT_BYTES(BB)) u_rom (
    .clk(clk), .rom_cs(rom_cs), .rom_oe(rom_oe), .rom_addr(rom_addr),
    .external_data_lines(ext_data), .wide(cfg_wide), .big(cfg_big),
    .corr_on(cfg_corr), .slow(slow), .mem_wr_ready(mem_wr_ready));

  // ----------------------------------------------------------------
  // Checking helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Image byte as laid down in the ROM
  function automatic logic [7:0] img(input int a);
    return 8'(a * 29) ^ 8'h5A;
  endfunction

  // Packed word: first unit lowest in little, highest in big order
  function automatic logic [31:0] exp_word(input int n, input logic wide,
                                           input logic big);
    logic [31:0] w;
    for (int k = 0; k < 4; k++) begin
      w[8*k +: 8] = img(4 * n + (big ? (wide ? k ^ 2 : 3 - k) : k));
    end
    return w;
  endfunction

  // Destination writes against the image
  always @(posedge clk) begin
    if (rst || !ext_reset_n) begin
      wcnt <= 0;
    end else if (mem_wr_valid && mem_wr_ready) begin
      check(mem_wr_addr, 32'(4 * wcnt));
      check(mem_wr_data, exp_word(wcnt, cfg_wide, cfg_big));
      wcnt <= wcnt + 1;
    end
  end

  // Byte lanes during every ROM strobe
  always @(posedge clk) begin
    if (rom_oe === 1'b1)
      check({up_lane, lo_lane}, cfg_wide ? 2'h3 : (cfg_big && !cfg_corr) ? 2'h2 : 2'h1);
  end

  // ----------------------------------------------------------------
  // Bus and sequence tasks
  // ----------------------------------------------------------------
  task automatic reg_write(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_read(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask

  // Stall must hold until the start pulse, which comes within limit
  task automatic wait_start(input int limit);
    int n;
    n = 0;
    #1;
    while (core_start !== 1'b1 && n < limit) begin
      @(posedge clk);
      #1;
      n++;
      if (core_start !== 1'b1) check(core_stall, 1'b1);
    end
    check(core_start, 1'b1);
    check(start_addr, 32'h0);
  endtask

  // Pin reset with new straps, then scramble the straps after sampling
  task automatic restart(input logic big, input logic corr, input logic wide,
                         input logic emu);
    @(posedge clk);
    ext_reset_n <= 1'b0;
    sel_strap <= !big;
    corr_strap <= !corr;
    boot_strap <= emu;
    width_strap <= wide;
    repeat (3) @(posedge clk);
    // Expectations switch only once the old copy is cut off
    cfg_big <= big;
    cfg_corr <= corr;
    cfg_wide <= wide;
    #1;
    check({core_reset, core_stall, core_start, rom_cs, mem_wr_valid}, 5'h18);
    @(posedge clk);
    ext_reset_n <= 1'b1;
    @(posedge clk);
    {sel_strap, corr_strap, boot_strap, width_strap} <= 4'($urandom);
    #1;
    check(core_reset, 1'b0);
  endtask

  task automatic rom_run(input logic big, input logic corr, input logic wide,
                         input logic slw);
    slow <= slw;
    restart(big, corr, wide, 1'b0);
    emu_release <= slw;
    wait_start(NW * 80);
    check(32'(wcnt), 32'(NW));
    emu_release <= 1'b0;
    @(posedge clk);
    #1;
    check({core_start, core_stall, big_endian}, {2'h0, big});
    reg_read(8'h04, d);
    check(d[10:0], {3'h4, 2'h0, 1'b1, 1'b0, wide, 1'b0, corr, big});
    reg_read(8'h08, d);
    check(d[7:0], 8'(NW));
  endtask

  task automatic emu_run(input logic by_reg);
    logic b;
    b = 1'($urandom);
    restart(b, b, 1'($urandom), 1'b1);
    repeat ($urandom_range(20, 3)) begin
      @(posedge clk);
      #1;
      check({core_stall, core_start, rom_cs}, 3'h4);
    end
    // Emulator has planted its address-0 breakpoint by now
    if (by_reg) begin
      reg_write(8'h00, 32'h1);
    end else begin
      @(posedge clk);
      emu_release <= 1'b1;
      @(posedge clk);
      emu_release <= 1'b0;
    end
    wait_start(4);
    check(32'(wcnt), 32'h0);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial forever #12.5 clk = ~clk;

  initial begin
    #500000;
    errors++;
    end_sim();
  end

  initial begin
    rst = 1'b1;
    ext_reset_n = 1'b1;
    {emu_release, reg_wr, reg_rd, slow} = 4'h0;
    {sel_strap, corr_strap, boot_strap, width_strap} = 4'hC;
    {cfg_big, cfg_corr, cfg_wide} = 3'h0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    errors = 0;
    samples_checked = 0;
    void'($urandom(24));
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    wait_start(NW * 80);
    check(big_endian, 1'b0);
    // Fixed corners: both widths, both orders, big order with and without correction
    rom_run(1'b0, 1'b0, 1'b0, 1'b0);
    rom_run(1'b0, 1'b0, 1'b1, 1'b1);
    rom_run(1'b1, 1'b1, 1'b0, 1'b1);
    rom_run(1'b1, 1'b1, 1'b1, 1'b0);
    rom_run(1'b1, 1'b0, 1'b0, 1'b1);
    for (int i = 0; i < 4; i++) begin
      d = $urandom;
      rom_run(d[0], d[0], d[1], d[2]);
    end
    emu_run(1'b0);
    emu_run(1'b1);
    // Abort a copy part way, then boot again
    restart(1'b0, 1'b0, 1'b1, 1'b0);
    repeat (25) @(posedge clk);
    #1;
    check(rom_cs | mem_wr_valid, 1'b1);
    rom_run(1'b1, 1'b1, 1'b0, 1'b0);
    // Unmapped and write-only places read as zero
    reg_read(8'h3C, d);
    check(d, 32'h0);
    reg_read(8'h00, d);
    check(d, 32'h0);
    @(posedge clk);
    #1;
    check(reg_rdata, 32'h0);
    end_sim();
  end
endmodule
`default_nettype wire
